// ### rtl/srp_pkg.sv
// Package for the serial register port: frame layout and timing constants.
// Assumes a single 10 MHz system clock on both ends.
package srp_pkg;

  // ==========================================================================
  // Frame layout
  localparam int          SRP_PREAMBLE_LEN = 32;
  localparam logic [1:0]  SRP_START        = 2'h1;
  localparam logic [1:0]  SRP_OPCODE       = 2'h0;
  localparam int          SRP_FIELD_W      = 5;
  localparam int          SRP_DATA_W       = 16;
  localparam int          SRP_REG_W        = 8;
  localparam int          SRP_ADDR_W       = 8;
  localparam int          SRP_RD_BIT       = 4;
  localparam int          SRP_UPPER_KEEP   = 3;
  localparam logic [7:0]  SRP_UPPER_ZERO   = 8'h00;
  localparam logic [7:0]  SRP_LAST_REG     = 8'h8D;
  // Header bits after the start pattern: opcode, two address fields
  localparam int          SRP_HDR_LEN      = 12;

  // ==========================================================================
  // Timing
  localparam int          SRP_CLK_HZ       = 10000000;
  localparam int          SRP_LINK_MAX_HZ  = 5000000;
  // Host makes the link clock: half period in system cycles, rounded up
  localparam int          SRP_HALF_CYC     =
    (SRP_CLK_HZ + 2 * SRP_LINK_MAX_HZ - 1) / (2 * SRP_LINK_MAX_HZ) < 1 ? 1 :
    (SRP_CLK_HZ + 2 * SRP_LINK_MAX_HZ - 1) / (2 * SRP_LINK_MAX_HZ);
  // Host keeps the link slow enough for the device's two-flop sampling
  localparam int          SRP_HALF_SLOW    = 4 * SRP_HALF_CYC;
  localparam logic [3:0]  SRP_HALF_LAST    = 4'(SRP_HALF_SLOW - 1);

endpackage

// ### rtl/srp_link_if.sv
// Two-wire management link: clock from the host and one shared data wire.
// The wire level is resolved here from the two enables, pulled up when idle.
`timescale 1ns/10ps
`default_nettype none
interface srp_link_if;
  logic mdc;
  logic mdio_host_o;
  logic mdio_host_oe;
  logic mdio_dev_o;
  logic mdio_dev_oe;
  logic mdio;

  assign mdio = mdio_host_oe ? mdio_host_o : (mdio_dev_oe ? mdio_dev_o : 1'b1);

  modport device (
    input  mdc,
    input  mdio,
    output mdio_dev_o,
    output mdio_dev_oe
  );

  modport host (
    output mdc,
    input  mdio,
    output mdio_host_o,
    output mdio_host_oe
  );
endinterface
`default_nettype wire

// ### rtl/srp_device.sv
// Device end of the serial register port: decodes frames into register
// reads and writes on an 8-bit register bank port.
// Assumes the bank returns read data combinationally for o_reg_addr.
`timescale 1ns/10ps
`default_nettype none
module srp_device
  import srp_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  srp_link_if.device                 link,
  input  wire logic [SRP_REG_W-1:0]  i_reg_rdata,
  output logic      [SRP_ADDR_W-1:0] o_reg_addr,
  output logic                       o_reg_wr,
  output logic      [SRP_REG_W-1:0]  o_reg_wdata,
  output logic                       o_reg_rd
);

  typedef enum {
    ST_PREAMBLE,
    ST_START,
    ST_HEADER,
    ST_TA,
    ST_WDATA,
    ST_RDATA
  } srp_dev_state_t;

  // ==========================================================================
  // Pin synchronisers
  logic [1:0] mdc_sync_reg;
  logic [1:0] mdio_sync_reg;
  logic       mdc_prev_reg;
  logic       mdc_rise;
  logic       mdc_fall;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mdc_sync_reg  <= 2'h0;
      mdio_sync_reg <= 2'h3;
      mdc_prev_reg  <= 1'b0;
    end else begin
      mdc_sync_reg  <= {mdc_sync_reg[0], link.mdc};
      mdio_sync_reg <= {mdio_sync_reg[0], link.mdio};
      mdc_prev_reg  <= mdc_sync_reg[1];
    end
  end

  assign mdc_rise = mdc_sync_reg[1] & ~mdc_prev_reg;
  assign mdc_fall = ~mdc_sync_reg[1] & mdc_prev_reg;

  // ==========================================================================
  // Frame decoder, sampled on link clock rising edges
  srp_dev_state_t              state_reg;
  logic [5:0]                  cnt_reg;
  logic [SRP_HDR_LEN-1:0]      hdr_reg;
  logic [SRP_DATA_W-1:0]       shift_reg;
  logic                        is_read_reg;
  logic                        bit_in;
  logic [SRP_HDR_LEN-1:0]      hdr_next;
  logic [SRP_ADDR_W-1:0]       addr_next;

  assign bit_in   = mdio_sync_reg[1];
  assign hdr_next = {hdr_reg[SRP_HDR_LEN-2:0], bit_in};
  // Bit 3 of the upper field is dropped here
  assign addr_next = {hdr_next[SRP_FIELD_W+SRP_UPPER_KEEP-1:SRP_FIELD_W],
                      hdr_next[SRP_FIELD_W-1:0]};

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg   <= ST_PREAMBLE;
      cnt_reg     <= 6'h00;
      hdr_reg     <= '0;
      is_read_reg <= 1'b0;
      o_reg_addr  <= 8'h00;
    end else if (mdc_rise) begin
      case (state_reg)
        ST_PREAMBLE: begin
          // Count consecutive ones, then look for the start pattern
          if (!bit_in) begin
            cnt_reg <= 6'h00;
          end else if (cnt_reg < 6'(SRP_PREAMBLE_LEN - 1)) begin
            // The 32nd one moves on, so the start's zero is not taken as a break
            cnt_reg <= cnt_reg + 6'h01;
          end else begin
            state_reg <= ST_START;
          end
        end
        ST_START: begin
          // First zero after the preamble is the start pattern's 0
          if (!bit_in) begin
            state_reg <= ST_HEADER;
            cnt_reg   <= 6'h00;
            hdr_reg   <= '0;
          end
        end
        ST_HEADER: begin
          if (cnt_reg == 6'h00 && !bit_in) begin
            state_reg <= ST_PREAMBLE;
          end else if (cnt_reg == 6'(SRP_HDR_LEN)) begin
            cnt_reg <= 6'h00;
            // The last address bit arrives on this edge, so decode the next value
            if (hdr_next[SRP_HDR_LEN-1 -: 2] == SRP_OPCODE) begin
              is_read_reg <= hdr_next[SRP_FIELD_W+SRP_RD_BIT];
              o_reg_addr  <= addr_next;
              state_reg   <= ST_TA;
            end else begin
              state_reg <= ST_PREAMBLE;
            end
          end else begin
            // Start pattern's 1 is taken at count 0 and not kept
            if (cnt_reg != 6'h00) begin
              hdr_reg <= hdr_next;
            end
            cnt_reg <= cnt_reg + 6'h01;
          end
        end
        ST_TA: begin
          if (cnt_reg == 6'h00) begin
            cnt_reg <= 6'h01;
          end else begin
            cnt_reg   <= 6'h00;
            state_reg <= is_read_reg ? ST_RDATA : ST_WDATA;
          end
        end
        ST_WDATA, ST_RDATA: begin
          if (cnt_reg == 6'(SRP_DATA_W - 1)) begin
            cnt_reg   <= 6'h00;
            state_reg <= ST_PREAMBLE;
          end else begin
            cnt_reg <= cnt_reg + 6'h01;
          end
        end
        default: begin
          state_reg <= ST_PREAMBLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Write path: strobe once the sixteenth bit is in
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      shift_reg   <= '0;
      o_reg_wr    <= 1'b0;
      o_reg_wdata <= 8'h00;
    end else begin
      o_reg_wr <= 1'b0;
      if (mdc_rise && state_reg == ST_WDATA) begin
        shift_reg <= {shift_reg[SRP_DATA_W-2:0], bit_in};
        if (cnt_reg == 6'(SRP_DATA_W - 1)) begin
          o_reg_wr    <= 1'b1;
          o_reg_wdata <= {shift_reg[SRP_REG_W-2:0], bit_in};
        end
      end
    end
  end

  // ==========================================================================
  // Read path: data changes on falling link edges so the host samples on rise
  logic [SRP_DATA_W-1:0] rd_shift_reg;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_shift_reg     <= '0;
      link.mdio_dev_o  <= 1'b1;
      link.mdio_dev_oe <= 1'b0;
      o_reg_rd         <= 1'b0;
    end else begin
      o_reg_rd <= 1'b0;
      if (mdc_fall) begin
        if (state_reg == ST_TA && is_read_reg && cnt_reg == 6'h01) begin
          // Second turnaround bit: drive zero and latch the register
          link.mdio_dev_oe <= 1'b1;
          link.mdio_dev_o  <= 1'b0;
          rd_shift_reg     <= {SRP_UPPER_ZERO, i_reg_rdata};
          o_reg_rd         <= 1'b1;
        end else if (state_reg == ST_RDATA) begin
          link.mdio_dev_oe <= 1'b1;
          link.mdio_dev_o  <= rd_shift_reg[SRP_DATA_W-1];
          rd_shift_reg     <= {rd_shift_reg[SRP_DATA_W-2:0], 1'b0};
        end else begin
          link.mdio_dev_oe <= 1'b0;
          link.mdio_dev_o  <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### rtl/srp_host.sv
// Host end of the serial register port: builds read and write frames on
// request and makes the link clock by dividing the system clock.
// Assumes one request at a time, held off while o_busy is high.
`timescale 1ns/10ps
`default_nettype none
module srp_host
  import srp_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  srp_link_if.host                   link,
  input  wire logic                  i_req,
  input  wire logic                  i_req_read,
  input  wire logic [SRP_ADDR_W-1:0] i_req_addr,
  input  wire logic [SRP_REG_W-1:0]  i_req_wdata,
  output logic                       o_busy,
  output logic                       o_done,
  output logic      [SRP_REG_W-1:0]  o_rdata
);

  localparam int FRAME_LEN = SRP_PREAMBLE_LEN + 2 + SRP_HDR_LEN + 2 + SRP_DATA_W;
  localparam int TA_POS    = SRP_PREAMBLE_LEN + 2 + SRP_HDR_LEN;
  localparam int DATA_POS  = TA_POS + 2;

  // ==========================================================================
  // Link clock divider: kept well below 5 MHz for the device's sampling
  logic [3:0] div_reg;
  logic       half_tick;

  assign half_tick = (div_reg == SRP_HALF_LAST);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_reg <= 4'h0;
    end else if (half_tick) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  // ==========================================================================
  // Frame sequencer: data changes while the clock is low
  logic [FRAME_LEN-1:0] frame_reg;
  logic [5:0]           bit_cnt_reg;
  logic                 read_reg;
  logic [SRP_REG_W-1:0] rx_reg;
  logic [6:0]           pos_reg;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      link.mdc          <= 1'b0;
      link.mdio_host_o  <= 1'b1;
      link.mdio_host_oe <= 1'b0;
      frame_reg         <= '0;
      pos_reg           <= 7'h00;
      read_reg          <= 1'b0;
      rx_reg            <= 8'h00;
      o_busy            <= 1'b0;
      o_done            <= 1'b0;
      o_rdata           <= 8'h00;
      bit_cnt_reg       <= 6'h00;
    end else begin
      o_done <= 1'b0;
      if (!o_busy) begin
        if (i_req) begin
          o_busy   <= 1'b1;
          read_reg <= i_req_read;
          pos_reg  <= 7'h00;
          // Read sets upper bit 4, write clears it; bit 3 sent as zero
          frame_reg <= {{SRP_PREAMBLE_LEN{1'b1}}, SRP_START, SRP_OPCODE,
                        i_req_read, 1'b0, i_req_addr, 2'h2,
                        SRP_UPPER_ZERO, i_req_wdata};
        end
      end else if (half_tick) begin
        link.mdc <= ~link.mdc;
        if (link.mdc) begin
          // Falling edge: present next bit
          if (pos_reg == 7'(FRAME_LEN)) begin
            link.mdio_host_oe <= 1'b0;
            o_busy            <= 1'b0;
            o_done            <= 1'b1;
            o_rdata           <= rx_reg;
            link.mdc          <= 1'b0;
          end else begin
            link.mdio_host_oe <= !(read_reg && pos_reg >= 7'(TA_POS));
            link.mdio_host_o  <= frame_reg[FRAME_LEN-1];
            frame_reg         <= {frame_reg[FRAME_LEN-2:0], 1'b0};
            pos_reg           <= pos_reg + 7'h01;
          end
        end else if (read_reg && pos_reg > 7'(DATA_POS + SRP_REG_W)) begin
          rx_reg <= {rx_reg[SRP_REG_W-2:0], link.mdio};
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### bench/srp_asserts.sv
// Checker for the management link joining the host and device ends.
// Takes the link wires as plain inputs; the bench places it beside the link.
`timescale 1ns/10ps
`default_nettype none
module srp_asserts (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic mdc,
  input wire logic mdio,
  input wire logic mdio_host_o,
  input wire logic mdio_host_oe,
  input wire logic mdio_dev_o,
  input wire logic mdio_dev_oe
);
  // ==========================================================================
  // Cycles since each end began driving, saturating
  logic [9:0] hcnt_reg;
  logic [7:0] dcnt_reg;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) hcnt_reg <= '0;
    else if (!mdio_host_oe) hcnt_reg <= '0;
    else if (hcnt_reg != '1) hcnt_reg <= hcnt_reg + 10'h1;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) dcnt_reg <= '0;
    else if (!mdio_dev_oe) dcnt_reg <= '0;
    else if (dcnt_reg != '1) dcnt_reg <= dcnt_reg + 8'h1;
  end

  // ==========================================================================
  // Properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  // Host gone quiet for half a bit, then the device opens with a zero
  sequence s_turn;
    !$past(mdio_host_oe, 4) ##0 !mdio_dev_o ##0 !mdio;
  endsequence

  a_one_driver: assert property (!(mdio_host_oe && mdio_dev_oe))
    else $error("both ends drive the data wire");
  a_mdc_slow: assert property ($changed(mdc) |=> $stable(mdc) [*3])
    else $error("link clock half period too short");
  a_turn_zero: assert property ($rose(mdio_dev_oe) |-> s_turn)
    else $error("bad read turnaround");
  a_upper_zero: assert property (mdio_dev_oe && dcnt_reg < 8'h42 |-> !mdio_dev_o)
    else $error("read upper byte not zero");
  a_dev_release: assert property ($fell(mdio_dev_oe) |-> $past(dcnt_reg) inside {[8'h80:8'h96]})
    else $error("device drive length wrong");
  a_preamble_ones: assert property (mdio_host_oe && hcnt_reg < 10'h0F8 |-> mdio_host_o)
    else $error("preamble bit not one");
  a_start_pat: assert property (hcnt_reg == 10'h102 |-> !mdio_host_o ##8 mdio_host_o)
    else $error("start pattern wrong");
  a_opcode_zero: assert property (hcnt_reg inside {[10'h112:10'h11E]} |-> !mdio_host_o)
    else $error("opcode not zero");
  a_frame_len: assert property ($fell(mdio_host_oe) |-> $past(hcnt_reg) inside {[10'h168:10'h178], [10'h1F8:10'h208]})
    else $error("host drive length wrong");
endmodule
`default_nettype wire

// ### bench/tb_serial_mgmt_register_port.sv
// Bench: host and device on one link; a second device on its own link
// takes frames bit-banged here, some of them broken on purpose.
`timescale 1ns/10ps
`default_nettype none
module tb_serial_mgmt_register_port import srp_pkg::*;;
  // ==========================================================================
  // Signals, ends and register banks
  logic        i_clk    = 1'b0;
  logic        i_resetn = 1'b0;
  logic        req, rd, busy, done, wr1, wr2, s, rd2;
  logic [7:0]  ra, rwd, rdata, a1, wd1, a2, wd2, wa2, wv2;
  logic [7:0]  bank [256];
  logic [7:0]  ta [5] = '{8'h00, 8'h05, 8'h1D, 8'h5A, SRP_LAST_REG};
  logic [7:0]  td [5] = '{8'hA1, 8'h5E, 8'h00, 8'hFF, 8'h3C};
  logic [17:0] got;
  int          n_fail, comparisons, wr2_n, rd2_n;

  always #50 i_clk = ~i_clk;
  srp_link_if lk ();
  srp_link_if lk2 ();
  srp_host u_srp_host (.i_clk(i_clk), .i_resetn(i_resetn), .link(lk), .i_req(req),
    .i_req_read(rd), .i_req_addr(ra), .i_req_wdata(rwd), .o_busy(busy),
    .o_done(done), .o_rdata(rdata));
  srp_device u_srp_device (.i_clk(i_clk), .i_resetn(i_resetn), .link(lk),
    .i_reg_rdata(bank[a1]), .o_reg_addr(a1), .o_reg_wr(wr1), .o_reg_wdata(wd1), .o_reg_rd());
  // Read data of the second bank is a fixed function of the address
  srp_device u_srp_device2 (.i_clk(i_clk), .i_resetn(i_resetn), .link(lk2),
    .i_reg_rdata(a2 ^ 8'hA5), .o_reg_addr(a2), .o_reg_wr(wr2), .o_reg_wdata(wd2), .o_reg_rd(rd2));
  srp_asserts u_srp_asserts (.i_clk(i_clk), .i_resetn(i_resetn), .mdc(lk.mdc),
    .mdio(lk.mdio), .mdio_host_o(lk.mdio_host_o), .mdio_host_oe(lk.mdio_host_oe),
    .mdio_dev_o(lk.mdio_dev_o), .mdio_dev_oe(lk.mdio_dev_oe));

  always @(posedge i_clk) if (wr1 === 1'b1) bank[a1] <= wd1;
  always @(posedge i_clk) if (rd2 === 1'b1) rd2_n <= rd2_n + 1;
  always @(posedge i_clk) if (wr2 === 1'b1) begin
    wr2_n <= wr2_n + 1;
    wa2 <= a2;
    wv2 <= wd2;
  end

  // ==========================================================================
  // Tasks
  task chk(input logic [17:0] g, input logic [17:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task hreq(input logic r, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(negedge i_clk);
    {req, rd, ra, rwd} = {1'b1, r, a, d};
    for (k = 0; busy !== 1'b1 && k < 100; k++) @(negedge i_clk);
    req = 1'b0;
    for (k = 0; done !== 1'b1 && k < 2000; k++) @(negedge i_clk);
    chk(18'(done), 18'h1);
  endtask

  // One link bit, 8 cycles; the wire is sampled just before the rise
  task lbit(input logic b, input logic oe, output logic q);
    @(negedge i_clk);
    {lk2.mdc, lk2.mdio_host_o, lk2.mdio_host_oe} = {1'b0, b, oe};
    repeat (3) @(negedge i_clk);
    q = lk2.mdio;
    lk2.mdc = 1'b1;
    repeat (4) @(negedge i_clk);
  endtask

  task send(input logic [63:0] v, input int n, input int idl);
    for (int i = n - 1; i >= 0; i--) lbit(v[i], 1'b1, s);
    repeat (idl) lbit(1'b1, 1'b0, s);
  endtask

  function automatic logic [45:0] hd(input logic r, input logic b3, input logic [7:0] a);
    return {32'hFFFF_FFFF, SRP_START, SRP_OPCODE, r, b3, a};
  endfunction

  task lread(input logic b3, input logic [7:0] a);
    send(64'(hd(1'b1, b3, a)), 46, 0);
    for (int i = 17; i >= 0; i--) begin
      lbit(1'b1, 1'b0, s);
      got[i] = s;
    end
    lbit(1'b1, 1'b0, s);
  endtask

  task results();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    {req, rd, ra, rwd} = '0;
    {lk2.mdc, lk2.mdio_host_o, lk2.mdio_host_oe} = 3'h2;
    repeat (6) @(negedge i_clk);
    i_resetn = 1'b1;
    foreach (ta[i]) hreq(1'b0, ta[i], td[i]);
    foreach (ta[i]) begin
      chk(18'(bank[ta[i]]), 18'(td[i]));
      hreq(1'b1, ta[i], 8'h00);
      chk(18'(rdata), 18'(td[i]));
    end
    $display("test host_rw ended");
    send({hd(1'b0, 1'b1, 8'h8D), 2'h2, 8'hFF, 8'h3C}, 64, 1);
    chk(18'({wa2, wv2}), 18'({8'h8D, 8'h3C}));
    send(64'({hd(1'b0, 1'b0, 8'h33), 2'h2, 8'h00, 7'h55}), 63, 0);
    chk(18'(wr2_n), 18'h1);
    send(64'h1, 1, 1);
    chk(18'({wa2, wv2}), 18'({8'h33, 8'hAB}));
    for (int op = 1; op < 4; op++) send({32'hFFFF_FFFF, 2'h1, 2'(op), 10'h022, 2'h2, 16'h0055}, 64, 1);
    chk(18'(wr2_n), 18'h2);
    $display("test link_write ended");
    lread(1'b1, 8'hA7);
    chk(got, {2'h2, 8'h00, 8'hA7 ^ 8'hA5});
    lread(1'b0, 8'h8D);
    chk(got, {2'h2, 8'h00, 8'h8D ^ 8'hA5});
    chk(18'(rd2_n), 18'h2);
    $display("test link_read ended");
    results();
  end

  // Whole run needs about 9000 cycles
  initial begin
    repeat (30000) @(posedge i_clk);
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
